// ===== dfpc_pkg.sv
// constants, types and register map of the data-flash partition command sequencer
// assumes one 250 MHz clock shared by the apb master and the flash array controller

package dfpc_pkg;

  // ==========================================================================
  // command codes and command word indices
  localparam logic [7:0]  CMD_PARTITION  = 8'h20;
  localparam logic [7:0]  CMD_EMU_QUERY  = 8'h15;  // value arbitrary
  localparam logic [2:0]  IDX_CMD        = 3'h0;
  localparam logic [2:0]  IDX_DIRECT     = 3'h1;
  localparam logic [2:0]  IDX_BUFFER     = 3'h2;
  localparam int          NUM_WORDS      = 8;

  // ==========================================================================
  // partition geometry, counted in sectors
  localparam logic [5:0]  DFLASH_SECTORS = 6'h20;   // 32 sectors of 256 bytes
  localparam int          SECTOR_BYTES   = 256;
  localparam logic [15:0] MAX_DIRECT     = 16'h0080;
  localparam logic [15:0] MAX_BUFFER     = 16'h0008;
  localparam logic [15:0] MIN_EMU        = 16'h000C;
  localparam logic [15:0] MIN_RATIO      = 16'h0008;
  localparam logic [22:0] INFO_ADDR0     = 23'h12_0000;
  localparam logic [22:0] INFO_ADDR1     = 23'h12_0002;

  // ==========================================================================
  // register byte offsets
  localparam logic [7:0]  OFS_INDEX      = 8'h00;
  localparam logic [7:0]  OFS_DATA       = 8'h04;
  localparam logic [7:0]  OFS_STATUS     = 8'h08;
  localparam logic [7:0]  OFS_MODE       = 8'h0C;
  localparam logic [7:0]  OFS_PART       = 8'h10;
  localparam logic [7:0]  OFS_IRQ_STAT   = 8'h14;
  localparam logic [7:0]  OFS_IRQ_CLR    = 8'h18;
  localparam logic [7:0]  OFS_IRQ_EN     = 8'h1C;

  // field positions
  localparam int          ST_COMMAND_COMPLETE_FLAG        = 0;
  localparam int          ST_ACCESS_ERROR_FLAG      = 1;
  localparam int          ST_VFAIL       = 2;
  localparam int          MODE_LOCK      = 0;
  localparam int          IRQ_DONE       = 0;
  localparam int          IRQ_ERR        = 1;

  // ==========================================================================
  // sequencer states and flash operations
  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_VALID = 3'h1,
    ST_VER_D = 3'h2,
    ST_VER_I = 3'h3,
    ST_PROG0 = 3'h4,
    ST_PROG1 = 3'h5,
    ST_QUERY = 3'h6
  } dfpc_state_type;

  typedef enum logic [1:0] {
    OP_NONE     = 2'h0,
    OP_VERIFY_D = 2'h1,
    OP_VERIFY_I = 2'h2,
    OP_PROGRAM  = 2'h3
  } dfpc_op_type;

  // ==========================================================================
  // carriers
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } dfpc_apb_type;

  typedef struct packed {
    logic        req;
    dfpc_op_type op;
    logic [22:0] addr;
    logic [15:0] wdata;
    logic [5:0]  sectors;
  } dfpc_nvm_req_type;

  typedef struct packed {
    logic ack;
    logic fail;
  } dfpc_nvm_rsp_type;

endpackage

// ===== dfpc_sequencer.sv
// data-flash partition and emulation query command sequencer with apb registers
// assumes the flash array controller runs on the same clock and acks each operation
//
// Functional notes
// (R1) data flash block is 32 sectors of 256 bytes; sizes count sectors
// (R2) software fully erases all blocks before launching the partition command
// (R3) software loads code 0x20 at index 0, direct count at 1, buffer count at 2
// (R4) clearing command complete launches; validation, erase-verify, programming follow in order
// (R5) direct partition count above 128 is rejected
// (R6) buffer emulation count above 8 is rejected
// (R7) nonzero buffer count needs 128 minus direct count at least 12
// (R8) nonzero buffer count needs remaining sectors over buffer count at least 8
// (R9) after validation, erase-verify data flash block then information register
// (R10) program direct count into information register at 0x12_0000
// (R11) program duplicate direct count into information register at 0x12_0002
// (R12) query command launched with index not zero sets access error
// (R13) command not permitted in current mode sets access error
// (R14) failed validation sets access error, skips steps, sets command complete
// (R15) command complete set once all partition steps finish
`timescale 1ns/1ps

module dfpc_sequencer (
  // clock and reset
  input  wire logic                      clock,
  input  wire logic                      resetn,
  // apb slave
  input  wire dfpc_pkg::dfpc_apb_type    apb,
  output logic                           pready,
  output logic                           pslverr,
  output logic [31:0]                    prdata,
  // flash array controller
  output dfpc_pkg::dfpc_nvm_req_type     nvm_req,
  input  wire dfpc_pkg::dfpc_nvm_rsp_type nvm_rsp,
  // interrupt
  output logic                           irq
);
  import dfpc_pkg::*;

  // ==========================================================================
  // state
  typedef struct packed {
    dfpc_state_type         fsm;
    logic [2:0]             idx;
    logic [NUM_WORDS-1:0][15:0] words;
    logic                   command_complete_flag;
    logic                   access_error_flag;
    logic                   vfail;
    logic                   lock;
    logic [15:0]            part_direct;
    logic [15:0]            part_copy;
    logic [1:0]             irq_stat;
    logic [1:0]             irq_en;
    logic [31:0]            rdata;
    dfpc_op_type            op;
    logic [22:0]            addr;
    logic [15:0]            wdata;
  } dfpc_regs_type;

  dfpc_regs_type s_r;
  dfpc_regs_type s_nxt;

  // ==========================================================================
  // decode helpers
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    mapped = hit(a, OFS_INDEX) || hit(a, OFS_DATA) || hit(a, OFS_STATUS) || hit(a, OFS_MODE) ||
             hit(a, OFS_PART) || hit(a, OFS_IRQ_STAT) || hit(a, OFS_IRQ_CLR) || hit(a, OFS_IRQ_EN);
  endfunction

  // sizes check; floor(r/b) >= 8 is the same as r >= 8*b, so no divider is needed
  function automatic logic sizes_good(input logic [15:0] direct, input logic [15:0] buffer);
    logic [15:0] remain;
    logic [15:0] need;
    remain = MAX_DIRECT - direct;
    need   = 16'(buffer * MIN_RATIO);
    sizes_good = (direct <= MAX_DIRECT) && (buffer <= MAX_BUFFER) &&       // [R5] [R6]
                 ((buffer == 16'h0000) || (remain >= MIN_EMU)) &&           // [R7]
                 ((buffer == 16'h0000) || (remain >= need));                // [R8]
  endfunction

  // ==========================================================================
  // bus strobes; the slave never waits, so every access phase completes at once
  logic setup_ph;
  logic wr_acc;
  logic launch;
  logic [7:0] cmd_code;
  logic sizes_ok;
  logic err_evt;
  logic done_evt;

  assign setup_ph = apb.psel && !apb.penable;
  assign wr_acc   = apb.psel && apb.penable && apb.pwrite;
  assign launch   = wr_acc && hit(apb.paddr, OFS_STATUS) && apb.pwdata[ST_COMMAND_COMPLETE_FLAG] && s_r.command_complete_flag;  // [R4]
  assign cmd_code = s_r.words[IDX_CMD][15:8];                                                 // [R3]
  assign sizes_ok = sizes_good(s_r.words[IDX_DIRECT], s_r.words[IDX_BUFFER]);                 // [R3]

  assign pready  = 1'b1;
  assign pslverr = apb.psel && apb.penable && !mapped(apb.paddr);
  assign prdata  = s_r.rdata;
  assign irq     = |(s_r.irq_stat & s_r.irq_en);

  // flash request is a level held until the controller acks
  always_comb begin
    nvm_req.req     = (s_r.fsm == ST_VER_D) || (s_r.fsm == ST_VER_I) ||
                      (s_r.fsm == ST_PROG0) || (s_r.fsm == ST_PROG1);
    nvm_req.op      = s_r.op;
    nvm_req.addr    = s_r.addr;
    nvm_req.wdata   = s_r.wdata;
    nvm_req.sectors = DFLASH_SECTORS;  // [R1]
  end

  // ==========================================================================
  // next state: bus writes first, so hardware sets below win over software clears
  always_comb begin
    s_nxt    = s_r;
    err_evt  = 1'b0;
    done_evt = 1'b0;

    // read data is captured in the setup cycle and presented in the access cycle
    if (setup_ph) begin
      s_nxt.rdata = 32'h0000_0000;
      if (hit(apb.paddr, OFS_INDEX)) begin
        s_nxt.rdata[2:0] = s_r.idx;
      end
      if (hit(apb.paddr, OFS_DATA)) begin
        s_nxt.rdata[15:0] = s_r.words[s_r.idx];
      end
      if (hit(apb.paddr, OFS_STATUS)) begin
        s_nxt.rdata[ST_COMMAND_COMPLETE_FLAG]   = s_r.command_complete_flag;
        s_nxt.rdata[ST_ACCESS_ERROR_FLAG] = s_r.access_error_flag;
        s_nxt.rdata[ST_VFAIL]  = s_r.vfail;
      end
      if (hit(apb.paddr, OFS_MODE)) begin
        s_nxt.rdata[MODE_LOCK] = s_r.lock;
      end
      if (hit(apb.paddr, OFS_PART)) begin
        s_nxt.rdata = {s_r.part_copy, s_r.part_direct};
      end
      if (hit(apb.paddr, OFS_IRQ_STAT)) begin
        s_nxt.rdata[1:0] = s_r.irq_stat;
      end
      if (hit(apb.paddr, OFS_IRQ_EN)) begin
        s_nxt.rdata[1:0] = s_r.irq_en;
      end
    end

    // command words are frozen while a command runs
    if (wr_acc) begin
      if (hit(apb.paddr, OFS_INDEX) && s_r.command_complete_flag) begin
        s_nxt.idx = apb.pwdata[2:0];
      end
      if (hit(apb.paddr, OFS_DATA) && s_r.command_complete_flag) begin
        s_nxt.words[s_r.idx] = apb.pwdata[15:0];
      end
      if (hit(apb.paddr, OFS_STATUS)) begin
        if (apb.pwdata[ST_ACCESS_ERROR_FLAG]) begin
          s_nxt.access_error_flag = 1'b0;
        end
        if (apb.pwdata[ST_VFAIL]) begin
          s_nxt.vfail = 1'b0;
        end
      end
      if (hit(apb.paddr, OFS_MODE)) begin
        s_nxt.lock = apb.pwdata[MODE_LOCK];
      end
      if (hit(apb.paddr, OFS_IRQ_CLR)) begin
        s_nxt.irq_stat = s_r.irq_stat & ~apb.pwdata[1:0];
      end
      if (hit(apb.paddr, OFS_IRQ_EN)) begin
        s_nxt.irq_en = apb.pwdata[1:0];
      end
    end

    // sequencer
    unique case (s_r.fsm)
      ST_IDLE: begin
        if (launch) begin
          if ((cmd_code == CMD_EMU_QUERY) && (s_r.idx != IDX_CMD)) begin
            err_evt = 1'b1;  // [R12]
          end else if ((cmd_code == CMD_PARTITION) && !s_r.lock) begin
            s_nxt.command_complete_flag = 1'b0;  // [R4]
            s_nxt.fsm  = ST_VALID;
          end else if (cmd_code == CMD_EMU_QUERY) begin
            s_nxt.command_complete_flag = 1'b0;
            s_nxt.fsm  = ST_QUERY;
          end else begin
            err_evt = 1'b1;  // [R13]
          end
        end
      end
      ST_VALID: begin
        if (sizes_ok) begin
          s_nxt.fsm = ST_VER_D;  // [R4] [R9]
          s_nxt.op  = OP_VERIFY_D;
        end else begin
          err_evt    = 1'b1;  // [R14]
          s_nxt.command_complete_flag = 1'b1;
          s_nxt.fsm  = ST_IDLE;
        end
      end
      ST_VER_D, ST_VER_I, ST_PROG0, ST_PROG1: begin
        if (nvm_rsp.ack) begin
          if (nvm_rsp.fail) begin
            // a failed step aborts the rest of the command
            s_nxt.vfail = 1'b1;
            err_evt     = 1'b1;
            s_nxt.command_complete_flag  = 1'b1;
            s_nxt.fsm   = ST_IDLE;
            s_nxt.op    = OP_NONE;
          end else if (s_r.fsm == ST_VER_D) begin
            s_nxt.fsm = ST_VER_I;  // [R9]
            s_nxt.op  = OP_VERIFY_I;
          end else if (s_r.fsm == ST_VER_I) begin
            s_nxt.fsm   = ST_PROG0;
            s_nxt.op    = OP_PROGRAM;
            s_nxt.addr  = INFO_ADDR0;  // [R10]
            s_nxt.wdata = s_r.words[IDX_DIRECT];
          end else if (s_r.fsm == ST_PROG0) begin
            s_nxt.fsm   = ST_PROG1;
            s_nxt.addr  = INFO_ADDR1;  // [R11]
            s_nxt.wdata = s_r.words[IDX_DIRECT];
          end else begin
            s_nxt.part_direct = s_r.words[IDX_DIRECT];
            s_nxt.part_copy   = s_r.wdata;
            done_evt          = 1'b1;
            s_nxt.command_complete_flag        = 1'b1;  // [R15]
            s_nxt.fsm         = ST_IDLE;
            s_nxt.op          = OP_NONE;
          end
        end
      end
      ST_QUERY: begin
        // report the stored partition back through the command words
        s_nxt.words[IDX_DIRECT] = s_r.part_direct;
        s_nxt.words[IDX_BUFFER] = s_r.part_copy;
        done_evt                = 1'b1;
        s_nxt.command_complete_flag              = 1'b1;
        s_nxt.fsm               = ST_IDLE;
      end
      default: begin
        s_nxt.command_complete_flag = 1'b1;
        s_nxt.fsm  = ST_IDLE;
      end
    endcase

    // sticky flags, set after any clear so a same-cycle event is kept
    if (err_evt) begin
      s_nxt.access_error_flag            = 1'b1;
      s_nxt.irq_stat[IRQ_ERR] = 1'b1;
    end
    if (done_evt) begin
      s_nxt.irq_stat[IRQ_DONE] = 1'b1;
    end
  end

  // ==========================================================================
  // register
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      s_r      <= '0;
      s_r.fsm  <= ST_IDLE;
      s_r.op   <= OP_NONE;
      s_r.command_complete_flag <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ==========================================================================
  // checks
  launch_clears_a: assert property (@(posedge clock) disable iff (!resetn)  // [R4]
    launch && (cmd_code == CMD_PARTITION) && !s_r.lock |=> !s_r.command_complete_flag && (s_r.fsm == ST_VALID) ##1
    (s_r.fsm != ST_VALID))
    else $error("partition launch did not clear command complete");

  reject_direct_a: assert property (@(posedge clock) disable iff (!resetn)  // [R5]
    (s_r.fsm == ST_VALID) && (s_r.words[IDX_DIRECT] > MAX_DIRECT) |=> s_r.access_error_flag && s_r.command_complete_flag)
    else $error("oversized direct partition accepted");

  reject_buffer_a: assert property (@(posedge clock) disable iff (!resetn)  // [R6]
    (s_r.fsm == ST_VALID) && (s_r.words[IDX_BUFFER] > MAX_BUFFER) |=> s_r.access_error_flag && (s_r.fsm == ST_IDLE))
    else $error("oversized buffer partition accepted");

  min_emu_a: assert property (@(posedge clock) disable iff (!resetn)  // [R7]
    (s_r.fsm == ST_VALID) && (s_r.words[IDX_BUFFER] != 16'h0000) && (s_r.words[IDX_DIRECT] <= MAX_DIRECT) &&
    ((MAX_DIRECT - s_r.words[IDX_DIRECT]) < MIN_EMU) |=> s_r.access_error_flag && (s_r.fsm == ST_IDLE))
    else $error("too few emulation sectors accepted");

  ratio_a: assert property (@(posedge clock) disable iff (!resetn)  // [R8]
    (s_r.fsm == ST_VALID) && sizes_ok |-> (s_r.words[IDX_BUFFER] == 16'h0000) ||
    (((MAX_DIRECT - s_r.words[IDX_DIRECT]) / s_r.words[IDX_BUFFER]) >= MIN_RATIO))
    else $error("emulation ratio below minimum accepted");

  verify_order_a: assert property (@(posedge clock) disable iff (!resetn)  // [R9]
    (s_r.fsm == ST_VER_D) && nvm_rsp.ack && !nvm_rsp.fail |=> nvm_req.req && (nvm_req.op == OP_VERIFY_I))
    else $error("information register verify did not follow");

  prog_first_a: assert property (@(posedge clock) disable iff (!resetn)  // [R10]
    $rose(s_r.fsm == ST_PROG0) |-> nvm_req.req && (nvm_req.addr == INFO_ADDR0) &&
    (nvm_req.wdata == s_r.words[IDX_DIRECT]))
    else $error("first partition copy wrong");

  prog_second_a: assert property (@(posedge clock) disable iff (!resetn)  // [R11]
    (s_r.fsm == ST_PROG0) && nvm_rsp.ack && !nvm_rsp.fail |=> (nvm_req.addr == INFO_ADDR1) &&
    (nvm_req.wdata == s_r.words[IDX_DIRECT]))
    else $error("duplicate partition copy wrong");

  query_index_a: assert property (@(posedge clock) disable iff (!resetn)  // [R12]
    launch && (cmd_code == CMD_EMU_QUERY) && (s_r.idx != IDX_CMD) |=> s_r.access_error_flag && s_r.command_complete_flag && s_r.irq_stat[IRQ_ERR])
    else $error("query with bad index not flagged");

  mode_block_a: assert property (@(posedge clock) disable iff (!resetn)  // [R13]
    launch && (cmd_code == CMD_PARTITION) && s_r.lock |=> s_r.access_error_flag && (s_r.fsm == ST_IDLE))
    else $error("locked partition launch not flagged");

  fail_skip_a: assert property (@(posedge clock) disable iff (!resetn)  // [R14]
    (s_r.fsm == ST_VALID) && !sizes_ok |=> s_r.command_complete_flag && !nvm_req.req ##1 !nvm_req.req)
    else $error("failed validation did not abort");

  done_sets_a: assert property (@(posedge clock) disable iff (!resetn)  // [R15]
    (s_r.fsm == ST_PROG1) && nvm_rsp.ack && !nvm_rsp.fail |=> s_r.command_complete_flag && s_r.irq_stat[IRQ_DONE] &&
    (s_r.part_direct == s_r.part_copy))
    else $error("command complete not set after programming");

  sectors_fixed_a: assert property (@(posedge clock) disable iff (!resetn)  // [R1]
    nvm_req.req |-> (nvm_req.sectors == DFLASH_SECTORS))
    else $error("flash request sector count wrong");

  busy_req_a: assert property (@(posedge clock) disable iff (!resetn)  // [R4]
    nvm_req.req |-> !s_r.command_complete_flag && (s_r.fsm != ST_IDLE))
    else $error("flash request while no command runs");

  verify_abort_a: assert property (@(posedge clock) disable iff (!resetn)  // [R9]
    ((s_r.fsm == ST_VER_D) || (s_r.fsm == ST_VER_I)) && nvm_rsp.ack && nvm_rsp.fail |=>
    s_r.vfail && s_r.access_error_flag && s_r.command_complete_flag && !nvm_req.req)
    else $error("failed verify did not abort the command");

  query_err_wins_a: assert property (@(posedge clock) disable iff (!resetn)  // [R12]
    launch && (cmd_code == CMD_EMU_QUERY) && (s_r.idx != IDX_CMD) && apb.pwdata[ST_ACCESS_ERROR_FLAG] |=> s_r.access_error_flag)
    else $error("access error clear beat a same-cycle query error");

endmodule

// ===== dfpc_sequencer_test.sv
// self-checking bench for the data-flash partition command sequencer
// assumes dfpc_pkg and dfpc_sequencer are compiled first; the bench plays apb master and flash controller
`timescale 1ns/1ps

module dfpc_sequencer_test;
  import dfpc_pkg::*;

  // ==========================================================================
  // design ports and bench state
  logic             clock;
  logic             resetn;
  dfpc_apb_type     apb;
  logic             pready;
  logic             pslverr;
  logic [31:0]      prdata;
  dfpc_nvm_req_type nvm_req;
  dfpc_nvm_rsp_type nvm_rsp;
  logic             irq;
  int               n_fail;
  int               comparisons;
  int               ack_delay;
  int               wait_cnt;
  logic             fail_arm;
  logic [40:0]      op_log[$];

  dfpc_sequencer dut (
    .clock   (clock),
    .resetn  (resetn),
    .apb     (apb),
    .pready  (pready),
    .pslverr (pslverr),
    .prdata  (prdata),
    .nvm_req (nvm_req),
    .nvm_rsp (nvm_rsp),
    .irq     (irq)
  );

  // ==========================================================================
  // clock and flash controller stand-in
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  // acks each held request after ack_delay cycles; one drive of nvm_rsp per edge avoids double assignment
  always @(posedge clock) begin
    if (nvm_req.req === 1'b1 && nvm_rsp.ack !== 1'b1 && wait_cnt >= ack_delay) begin
      nvm_rsp <= '{ack: 1'b1, fail: fail_arm};
      op_log.push_back({nvm_req.op, nvm_req.addr, nvm_req.wdata});
      wait_cnt = 0;
    end else begin
      nvm_rsp <= '{ack: 1'b0, fail: 1'b0};
      if (nvm_req.req === 1'b1 && nvm_rsp.ack !== 1'b1) wait_cnt = wait_cnt + 1;
    end
  end

  // ==========================================================================
  // shared tasks
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one apb transfer; the request holds until pready is seen high, wait is bounded
  task automatic apb_xfer(input logic wr_en, input logic [7:0] addr, input logic [31:0] wdata,
                          output logic [31:0] rdata, output logic err);
    int n;
    n = 0;
    @(posedge clock);
    apb <= '{psel: 1'b1, penable: 1'b0, pwrite: wr_en, paddr: addr, pwdata: wdata};
    @(posedge clock);
    apb.penable <= 1'b1;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 100);
    if (n >= 100) begin
      n_fail++;
      $display("[ERR] apb pready expected 1 seen %b", pready);
    end
    rdata = prdata;
    err = pslverr;
    apb.psel <= 1'b0;
    apb.penable <= 1'b0;
    // return mid-cycle so outputs registered at the access edge have settled before the caller looks
    @(negedge clock);
  endtask

  task automatic wr(input logic [7:0] addr, input logic [31:0] data);
    logic [31:0] d;
    logic        e;
    apb_xfer(1'b1, addr, data, d, e);
  endtask

  task automatic rd(input logic [7:0] addr, output logic [31:0] data);
    logic e;
    apb_xfer(1'b0, addr, 32'h0000_0000, data, e);
  endtask

  // clears stale flags, loads words 0..2, leaves the index at idx, launches and polls for completion
  task automatic run_cmd(input logic [15:0] w0, input logic [15:0] w1, input logic [15:0] w2,
                         input logic [2:0] idx, output logic [31:0] st);
    int n;
    wr(OFS_STATUS, 32'h0000_0006);
    wr(OFS_IRQ_CLR, 32'h0000_0003);
    wr(OFS_INDEX, 32'h0000_0000);
    wr(OFS_DATA, {16'h0000, w0});
    wr(OFS_INDEX, 32'h0000_0001);
    wr(OFS_DATA, {16'h0000, w1});
    wr(OFS_INDEX, 32'h0000_0002);
    wr(OFS_DATA, {16'h0000, w2});
    wr(OFS_INDEX, {29'h0, idx});
    op_log.delete();
    // launch also clears the access error, so a launch-time error must win over that clear
    wr(OFS_STATUS, 32'h0000_0003);
    n = 0;
    do begin
      rd(OFS_STATUS, st);
      n++;
    end while (st[ST_COMMAND_COMPLETE_FLAG] !== 1'b1 && n < 100);
    if (n >= 100) begin
      n_fail++;
      $display("[ERR] command complete expected 1 seen %b", st[ST_COMMAND_COMPLETE_FLAG]);
    end
  endtask

  // sizes accepted by the partition checks, worked out independently of the design
  function automatic bit sizes_ok(input int dir, input int bufc);
    if (dir > 128 || bufc > 8) return 1'b0;
    if (bufc == 0) return 1'b1;
    return ((128 - dir) >= 12) && (((128 - dir) / bufc) >= 8);
  endfunction

  // ==========================================================================
  // scenarios
  task automatic test_reset();
    logic [31:0] v;
    logic        e;
    rd(OFS_STATUS, v);
    chk("status at reset", 32'h0000_0001, v);
    rd(OFS_PART, v);
    chk("part at reset", 32'h0000_0000, v);
    chk("irq at reset", 32'h0, {31'h0, irq});
    apb_xfer(1'b0, 8'h20, 32'h0000_0000, v, e);
    chk("unmapped read data", 32'h0, v);
    chk("unmapped error", 32'h1, {31'h0, e});
    $display("test reset done");
  endtask

  // slow acks stretch every step; the operations must still come in order with the right targets
  task automatic test_partition();
    logic [31:0] st;
    logic [31:0] v;
    wr(OFS_IRQ_EN, 32'h0000_0003);
    ack_delay = 3;
    run_cmd({CMD_PARTITION, 8'h00}, 16'h0074, 16'h0001, 3'h0, st);
    ack_delay = 0;
    chk("status after partition", 32'h0000_0001, st);
    chk("flash op count", 32'd4, 32'(op_log.size()));
    if (op_log.size() == 4) begin
      chk("op 0", {30'h0, OP_VERIFY_D}, {30'h0, op_log[0][40:39]});
      chk("op 1", {30'h0, OP_VERIFY_I}, {30'h0, op_log[1][40:39]});
      chk("op 2", {30'h0, OP_PROGRAM}, {30'h0, op_log[2][40:39]});
      chk("op 2 addr", {9'h0, INFO_ADDR0}, {9'h0, op_log[2][38:16]});
      chk("op 2 data", 32'h0000_0074, {16'h0, op_log[2][15:0]});
      chk("op 3", {30'h0, OP_PROGRAM}, {30'h0, op_log[3][40:39]});
      chk("op 3 addr", {9'h0, INFO_ADDR1}, {9'h0, op_log[3][38:16]});
      chk("op 3 data", 32'h0000_0074, {16'h0, op_log[3][15:0]});
    end
    chk("verify sector count", 32'd32, {26'h0, nvm_req.sectors});
    rd(OFS_PART, v);
    chk("stored partition", 32'h0074_0074, v);
    chk("irq on done", 32'h1, {31'h0, irq});
    rd(OFS_IRQ_STAT, v);
    chk("irq status done", 32'h0000_0001, v);
    wr(OFS_IRQ_CLR, 32'h0000_0001);
    chk("irq after clear", 32'h0, {31'h0, irq});
    rd(OFS_IRQ_CLR, v);
    chk("clear reg reads zero", 32'h0, v);
    $display("test partition done");
  endtask

  task automatic test_query();
    logic [31:0] st;
    logic [31:0] v;
    run_cmd({CMD_EMU_QUERY, 8'h00}, 16'h0000, 16'h0000, 3'h1, st);
    chk("query bad index", 32'h0000_0003, st);
    chk("irq on error", 32'h1, {31'h0, irq});
    wr(OFS_IRQ_EN, 32'h0000_0001);
    chk("error irq masked", 32'h0, {31'h0, irq});
    rd(OFS_IRQ_STAT, v);
    chk("error stays sticky", 32'h0000_0002, v);
    wr(OFS_IRQ_EN, 32'h0000_0003);
    run_cmd({CMD_EMU_QUERY, 8'h00}, 16'h0000, 16'h0000, 3'h0, st);
    chk("query good index", 32'h0000_0001, st);
    wr(OFS_INDEX, 32'h0000_0001);
    rd(OFS_DATA, v);
    chk("query direct count", 32'h0000_0074, v);
    $display("test query done");
  endtask

  // boundary sizes either side of every limit
  task automatic test_validation();
    logic [15:0] dir_t[8] = '{16'h0080, 16'h0081, 16'h0000, 16'h0000, 16'h0074, 16'h0075, 16'h0040, 16'h0041};
    logic [15:0] buf_t[8] = '{16'h0000, 16'h0000, 16'h0008, 16'h0009, 16'h0001, 16'h0001, 16'h0008, 16'h0008};
    logic [31:0] st;
    bit          ok;
    for (int i = 0; i < 8; i++) begin
      ok = sizes_ok(int'(dir_t[i]), int'(buf_t[i]));
      run_cmd({CMD_PARTITION, 8'h00}, dir_t[i], buf_t[i], 3'h0, st);
      chk("validation status", ok ? 32'h1 : 32'h3, st);
      chk("validation op count", ok ? 32'd4 : 32'd0, 32'(op_log.size()));
    end
    $display("test validation done");
  endtask

  task automatic test_lock();
    logic [31:0] st;
    wr(OFS_MODE, 32'h0000_0001);
    run_cmd({CMD_PARTITION, 8'h00}, 16'h0010, 16'h0001, 3'h0, st);
    chk("locked launch", 32'h0000_0003, st);
    chk("locked op count", 32'd0, 32'(op_log.size()));
    wr(OFS_MODE, 32'h0000_0000);
    run_cmd(16'h0000, 16'h0010, 16'h0001, 3'h0, st);
    chk("unknown code launch", 32'h0000_0003, st);
    chk("unknown code op count", 32'd0, 32'(op_log.size()));
    $display("test lock done");
  endtask

  // a failed erase-verify must stop the sequence at once
  task automatic test_flash_fail();
    logic [31:0] st;
    fail_arm = 1'b1;
    run_cmd({CMD_PARTITION, 8'h00}, 16'h0010, 16'h0001, 3'h0, st);
    fail_arm = 1'b0;
    chk("verify failure status", 32'h0000_0007, st);
    chk("verify failure op count", 32'd1, 32'(op_log.size()));
    $display("test flash_fail done");
  endtask

  // ==========================================================================
  // verdict, main sequence and watchdog
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    n_fail = 0;
    comparisons = 0;
    ack_delay = 0;
    wait_cnt = 0;
    fail_arm = 1'b0;
    apb = '0;
    nvm_rsp = '0;
    resetn = 1'b0;
    repeat (4) @(posedge clock);
    resetn <= 1'b1;
    test_reset();
    test_partition();
    test_query();
    test_validation();
    test_lock();
    test_flash_fail();
    tally_and_finish();
  end

  // the whole run needs well under 20000 cycles
  initial begin
    #200000;
    n_fail++;
    tally_and_finish();
  end
endmodule
